//--- rtl/gpb_defines.svh
// offsets, field positions and reset values for the bank-two pin select block
`ifndef GPB_DEFINES_SVH
`define GPB_DEFINES_SVH
`define GPB_NUM_PINS 27
`define GPB_ADDR_W 8
`define GPB_OFS_SELECT 8'h84
`define GPB_OFS_LEVEL 8'h88
`define GPB_SELECT_RESET 27'h000_0000
`define GPB_LEVEL_RESET 27'h00F_FFFF
`define GPB_RSVD_ZERO 5'h00
`define GPB_BIT_PIN58 26
`define GPB_BIT_PIN57 25
`define GPB_BIT_PIN56 24
`define GPB_BIT_PIN55 23
`define GPB_BIT_PIN54 22
`define GPB_BIT_PIN53 21
`define GPB_BIT_MII_HI 20
`define GPB_BIT_MII_LO 8
`define GPB_BIT_MII_RXD_HI 19
`define GPB_BIT_MII_RXD_LO 16
`define GPB_BIT_MII_RXDV 15
`define GPB_BIT_MII_RXC 14
`define GPB_BIT_MII_TXEN 13
`define GPB_BIT_MII_TXD_HI 12
`define GPB_BIT_MII_TXD_LO 9
`define GPB_BIT_ISA_HI 7
`define GPB_BIT_ISA_LO 0
`define GPB_UNMAPPED_DATA 32'h0000_0000
`endif

//--- rtl/gpb_pkg.sv
// types shared by the bank-two pin select block
package gpb_pkg;
    typedef logic [26:0] gpb_pins_t;
    typedef logic [31:0] gpb_word_t;
    typedef logic [7:0] gpb_addr_t;
    typedef enum logic [1:0] {GPB_IDLE, GPB_ANSWER} gpb_state_t;
endpackage

//--- rtl/gpb_pin_cell.sv
`timescale 1ns/100ps
// one pad mux: normal function or general-purpose with weak pull-up
module gpb_pin_cell (
    // select
    input wire logic gp_select,
    input wire logic level,
    // normal function side
    input wire logic func_out,
    input wire logic func_oe,
    output logic func_in,
    // pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_pullup,
    output logic gp_in
);
    // in gp mode the pad drives low only; a 1 leaves the pull-up to hold it high
    always_comb begin
        pad_out = gp_select ? 1'b0 : func_out;
        pad_oe = gp_select ? ~level : func_oe;
        pad_pullup = gp_select;
        func_in = gp_select ? 1'b1 : pad_in;
        gp_in = pad_in;
    end
endmodule

//--- rtl/gpb_pin_select.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/100ps
// bank-two pin function select and level registers with avalon-mm slave
`include "gpb_defines.svh"

// What this block does
// - select bit 26 low gives pin 58 its second chip select / legacy clock input, high makes it gp pin 58.
// - select bit 25 low gives pin 57 its first chip select, high makes it gp pin 57.
// - select bit 24 low gives pin 56 its ethernet clock output, high makes it gp pin 56.
// - select bits 23..21 low give pins 55..53 keyboard reset, address line 20 gate and speaker, high make them gp.
// - select bits 20..8 low connect pins 52..40 to the mii port-0 signals, high make them gp.
// - select bits 7..0 low connect pins 39..32 to isa address lines 23..16, high make them gp.
// - a select bit of 1 hands its pin to gp control with a weak pull-up, 0 returns the normal function.
// - the level register at 0x88 holds one bit per pin, bit 26 for pin 58, and resets to 0xfffff.
// - the select register sits at 0x84 and resets to zero so every pin starts in its normal function.
// - in output mode a level bit drives its pin, in input mode reading it returns the pin's level.
module gpb_pin_select (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // avalon-mm slave
    input wire gpb_pkg::gpb_addr_t avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire gpb_pkg::gpb_word_t avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output gpb_pkg::gpb_word_t avs_readdata,
    output logic avs_waitrequest,
    // normal functions, bit n belongs to pin 32+n
    input wire gpb_pkg::gpb_pins_t func_out,
    input wire gpb_pkg::gpb_pins_t func_oe,
    output gpb_pkg::gpb_pins_t func_in,
    // pads
    input wire gpb_pkg::gpb_pins_t pad_in,
    output gpb_pkg::gpb_pins_t pad_out,
    output gpb_pkg::gpb_pins_t pad_oe,
    output gpb_pkg::gpb_pins_t pad_pullup
);
    import gpb_pkg::*;

    gpb_pins_t pin_function_select_bank_two;
    gpb_pins_t pin_level_bank_two;
    gpb_pins_t gp_in;
    gpb_pins_t next_select;
    gpb_pins_t next_level;
    gpb_state_t state;
    gpb_word_t byte_mask;
    logic access;
    logic hit_select;
    logic hit_level;
    // strobes for the commit edge and the read capture edge
    logic answer_cycle;
    logic write_select;
    logic write_level;
    logic capture_read;
    gpb_word_t read_word;
    // named views of the select bits, single-function pins 58..53
    logic pin58_gp_select;
    logic pin57_gp_select;
    logic pin56_gp_select;
    logic pin55_gp_select;
    logic pin54_gp_select;
    logic pin53_gp_select;
    // select views of the mii port-0 group, pins 52..40
    logic mii_col_gp_select;
    logic [3:0] mii_rxd_gp_select;
    logic mii_rxdv_gp_select;
    logic mii_rxc_gp_select;
    logic mii_txen_gp_select;
    logic [3:0] mii_txd_gp_select;
    logic mii_txc_gp_select;
    // select view of the isa upper address group, pins 39..32
    logic [7:0] isa_gp_select;
    // the same views for the level bits
    logic pin58_level;
    logic pin57_level;
    logic pin56_level;
    logic pin55_level;
    logic pin54_level;
    logic pin53_level;
    logic mii_col_level;
    logic [3:0] mii_rxd_level;
    logic mii_rxdv_level;
    logic mii_rxc_level;
    logic mii_txen_level;
    logic [3:0] mii_txd_level;
    logic mii_txc_level;
    logic [7:0] isa_level;
    // views put back together, bit n for pin 32+n
    gpb_pins_t pin_gp_select;
    gpb_pins_t pin_level;

    // decode and byte-lane mask
    assign access = avs_read | avs_write;
    assign hit_select = (avs_address == `GPB_OFS_SELECT);
    assign hit_level = (avs_address == `GPB_OFS_LEVEL);
    assign byte_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // one wait cycle, then the answer in the same cycle as waitrequest low
    assign avs_waitrequest = access & (state != GPB_ANSWER);

    // commit and capture strobes, all frozen with the clock enable
    assign answer_cycle = clk_en && (state == GPB_ANSWER);
    assign write_select = answer_cycle && avs_write && hit_select;
    assign write_level = answer_cycle && avs_write && hit_level;
    assign capture_read = clk_en && (state == GPB_IDLE) && avs_read;

    // single-function pins, 0 keeps the normal function
    assign pin58_gp_select = pin_function_select_bank_two[`GPB_BIT_PIN58];
    assign pin57_gp_select = pin_function_select_bank_two[`GPB_BIT_PIN57];
    assign pin56_gp_select = pin_function_select_bank_two[`GPB_BIT_PIN56];
    assign pin55_gp_select = pin_function_select_bank_two[`GPB_BIT_PIN55];
    assign pin54_gp_select = pin_function_select_bank_two[`GPB_BIT_PIN54];
    assign pin53_gp_select = pin_function_select_bank_two[`GPB_BIT_PIN53];
    // mii port-0 group, collision down to transmit clock
    assign mii_col_gp_select = pin_function_select_bank_two[`GPB_BIT_MII_HI];
    assign mii_rxd_gp_select = pin_function_select_bank_two[`GPB_BIT_MII_RXD_HI:`GPB_BIT_MII_RXD_LO];
    assign mii_rxdv_gp_select = pin_function_select_bank_two[`GPB_BIT_MII_RXDV];
    assign mii_rxc_gp_select = pin_function_select_bank_two[`GPB_BIT_MII_RXC];
    assign mii_txen_gp_select = pin_function_select_bank_two[`GPB_BIT_MII_TXEN];
    assign mii_txd_gp_select = pin_function_select_bank_two[`GPB_BIT_MII_TXD_HI:`GPB_BIT_MII_TXD_LO];
    assign mii_txc_gp_select = pin_function_select_bank_two[`GPB_BIT_MII_LO];
    // isa upper address group
    assign isa_gp_select = pin_function_select_bank_two[`GPB_BIT_ISA_HI:`GPB_BIT_ISA_LO];

    // level views, same bit layout as the select register
    assign pin58_level = pin_level_bank_two[`GPB_BIT_PIN58];
    assign pin57_level = pin_level_bank_two[`GPB_BIT_PIN57];
    assign pin56_level = pin_level_bank_two[`GPB_BIT_PIN56];
    assign pin55_level = pin_level_bank_two[`GPB_BIT_PIN55];
    assign pin54_level = pin_level_bank_two[`GPB_BIT_PIN54];
    assign pin53_level = pin_level_bank_two[`GPB_BIT_PIN53];
    assign mii_col_level = pin_level_bank_two[`GPB_BIT_MII_HI];
    assign mii_rxd_level = pin_level_bank_two[`GPB_BIT_MII_RXD_HI:`GPB_BIT_MII_RXD_LO];
    assign mii_rxdv_level = pin_level_bank_two[`GPB_BIT_MII_RXDV];
    assign mii_rxc_level = pin_level_bank_two[`GPB_BIT_MII_RXC];
    assign mii_txen_level = pin_level_bank_two[`GPB_BIT_MII_TXEN];
    assign mii_txd_level = pin_level_bank_two[`GPB_BIT_MII_TXD_HI:`GPB_BIT_MII_TXD_LO];
    assign mii_txc_level = pin_level_bank_two[`GPB_BIT_MII_LO];
    assign isa_level = pin_level_bank_two[`GPB_BIT_ISA_HI:`GPB_BIT_ISA_LO];

    // rebuild the per-pin vectors, pin 58 down to pin 32
    assign pin_gp_select = {pin58_gp_select, pin57_gp_select, pin56_gp_select,
                            pin55_gp_select, pin54_gp_select, pin53_gp_select,
                            mii_col_gp_select, mii_rxd_gp_select, mii_rxdv_gp_select, mii_rxc_gp_select,
                            mii_txen_gp_select, mii_txd_gp_select, mii_txc_gp_select, isa_gp_select};
    assign pin_level = {pin58_level, pin57_level, pin56_level,
                        pin55_level, pin54_level, pin53_level,
                        mii_col_level, mii_rxd_level, mii_rxdv_level, mii_rxc_level,
                        mii_txen_level, mii_txd_level, mii_txc_level, isa_level};

    // merged write values; upper reserved bits are dropped
    always_comb begin
        next_select = (pin_function_select_bank_two & ~byte_mask[26:0])
                      | (avs_writedata[26:0] & byte_mask[26:0]);
        next_level = (pin_level_bank_two & ~byte_mask[26:0])
                     | (avs_writedata[26:0] & byte_mask[26:0]);
    end

    // handshake state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= GPB_IDLE;
        end else if (clk_en) begin
            unique case (state)
                GPB_IDLE: state <= access ? GPB_ANSWER : GPB_IDLE;
                GPB_ANSWER: state <= GPB_IDLE;
            endcase
        end
    end

    // select register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_function_select_bank_two <= `GPB_SELECT_RESET;
        end else if (write_select) begin
            pin_function_select_bank_two <= next_select;
        end
    end

    // level register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_level_bank_two <= `GPB_LEVEL_RESET;
        end else if (write_level) begin
            pin_level_bank_two <= next_level;
        end
    end

    // read word by address; the level register reads the pads themselves
    always_comb begin
        read_word = `GPB_UNMAPPED_DATA;
        if (hit_select) begin
            read_word = {`GPB_RSVD_ZERO, pin_function_select_bank_two};
        end else if (hit_level) begin
            read_word = {`GPB_RSVD_ZERO, gp_in};
        end
    end

    // read data registered in the wait cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= `GPB_UNMAPPED_DATA;
        end else if (capture_read) begin
            avs_readdata <= read_word;
        end
    end

    // one mux per pin; bit order covers pins 58 down to 32 across all groups
    genvar i;
    generate
        for (i = 0; i < `GPB_NUM_PINS; i++) begin : g_pin
            gpb_pin_cell u_cell (
                .gp_select(pin_gp_select[i]),
                .level(pin_level[i]),
                .func_out(func_out[i]),
                .func_oe(func_oe[i]),
                .func_in(func_in[i]),
                .pad_in(pad_in[i]),
                .pad_out(pad_out[i]),
                .pad_oe(pad_oe[i]),
                .pad_pullup(pad_pullup[i]),
                .gp_in(gp_in[i])
            );
        end
    endgenerate
endmodule

//--- bench/gpb_pin_select_assertions.sv
// concurrent checks on the bank-two pin select ports
`timescale 1ns/100ps
module gpb_pin_select_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // avalon-mm slave
    input wire gpb_pkg::gpb_addr_t avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire gpb_pkg::gpb_word_t avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire gpb_pkg::gpb_word_t avs_readdata,
    input wire logic avs_waitrequest,
    // pins
    input wire gpb_pkg::gpb_pins_t func_out,
    input wire gpb_pkg::gpb_pins_t func_oe,
    input wire gpb_pkg::gpb_pins_t func_in,
    input wire gpb_pkg::gpb_pins_t pad_in,
    input wire gpb_pkg::gpb_pins_t pad_out,
    input wire gpb_pkg::gpb_pins_t pad_oe,
    input wire gpb_pkg::gpb_pins_t pad_pullup
);
    import gpb_pkg::*;
    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // normal pins follow the function side, gp pins never drive high and hold func_in high
    AST_NORM_OUT: assert property (((pad_out ^ func_out) & ~pad_pullup) == '0)
        else $error("pad_out differs from func_out");
    AST_NORM_OE: assert property (((pad_oe ^ func_oe) & ~pad_pullup) == '0)
        else $error("pad_oe differs from func_oe");
    AST_NORM_IN: assert property (((func_in ^ pad_in) & ~pad_pullup) == '0)
        else $error("func_in differs from pad_in");
    AST_GP_LOW: assert property ((pad_out & pad_pullup) == '0)
        else $error("gp pin drives high");
    AST_GP_IN: assert property ((~func_in & pad_pullup) == '0)
        else $error("func_in low on gp pin");
    // one wait cycle per access
    AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait cycle");
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
        else $error("answer late");
    AST_SEL_WR: assert property (avs_write && !avs_waitrequest && clk_en && avs_address == 8'h84 &&
        avs_byteenable == 4'hF |=> pad_pullup == $past(avs_writedata[26:0])) else $error("select write lost");
    AST_RSVD: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:27] == '0)
        else $error("reserved bits set");
endmodule

//--- bench/tb_top.sv
// self-checking bench for the bank-two pin select block
`timescale 1ns/100ps
module tb_top;
    import gpb_pkg::*;
    logic sys_clk = 0, rst = 1, clk_en = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [3:0] avs_byteenable = 4'hF;
    gpb_addr_t avs_address = '0;
    gpb_word_t avs_writedata = '0, avs_readdata, q;
    gpb_pins_t func_out = 27'h3C3_C3C3, func_oe = 27'h0F0_F0F3, pad_in = 27'h123_4567;
    gpb_pins_t func_in, pad_out, pad_oe, pad_pullup, s;
    int errors = 0, num_checks = 0;
    // clock
    always #20 sys_clk = ~sys_clk;
    gpb_pin_select gpb_pin_select_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .func_out(func_out),
        .func_oe(func_oe),
        .func_in(func_in),
        .pad_in(pad_in),
        .pad_out(pad_out),
        .pad_oe(pad_oe),
        .pad_pullup(pad_pullup)
    );
    task automatic chk(input string n, input gpb_word_t e, input gpb_word_t g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one bus access, held until waitrequest is low
    task automatic acc(input logic w, input gpb_addr_t a, input gpb_word_t d, input logic [3:0] be);
        @(posedge sys_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // pad outputs against select s and level l
    task automatic pins(input gpb_pins_t l);
        #1;
        chk("pad_out", {5'h0, func_out & ~s}, {5'h0, pad_out});
        chk("pad_oe", {5'h0, (func_oe & ~s) | (~l & s)}, {5'h0, pad_oe});
        chk("func_in", {5'h0, (pad_in & ~s) | s}, {5'h0, func_in});
        chk("pad_pullup", {5'h0, s}, {5'h0, pad_pullup});
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
    // test sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        acc(0, 8'h84, '0, 4'hF);
        chk("select reset", 32'h0000_0000, q);
        s = '0;
        pins(27'h00F_FFFF);
        acc(1, 8'h84, 32'hFFFF_FFFF, 4'hF);
        s = 27'h7FF_FFFF;
        pins(27'h00F_FFFF);
        acc(0, 8'h84, '0, 4'hF);
        chk("select rsvd", 32'h07FF_FFFF, q);
        acc(1, 8'h84, '0, 4'h1);
        acc(0, 8'h84, '0, 4'hF);
        chk("select byte", 32'h07FF_FF00, q);
        foreach (func_out[i]) if (i < 2) begin
            s = i ? 27'h2AA_AAAA : 27'h555_5555;
            acc(1, 8'h84, {5'h0, s}, 4'hF);
            acc(1, 8'h88, 32'h03C3_C3C3, 4'hF);
            pins(27'h3C3_C3C3);
        end
        acc(1, 8'h88, 32'h07FF_FFFF, 4'hF);
        pad_in <= 27'h5A5_A5A5;
        acc(0, 8'h88, '0, 4'hF);
        chk("level read", 32'h05A5_A5A5, q);
        acc(1, 8'h90, 32'hFFFF_FFFF, 4'hF);
        acc(0, 8'h90, '0, 4'hF);
        chk("unmapped", 32'h0000_0000, q);
        // frozen clock enable holds an access in its wait cycle
        clk_en <= 1'b0;
        fork
            acc(1, 8'h84, 32'h0000_00FF, 4'h1);
            begin
                repeat (4) @(posedge sys_clk);
                chk("frozen wait", 32'h0000_0001, {31'h0, avs_waitrequest});
                clk_en <= 1'b1;
            end
        join
        s = {s[26:8], 8'hFF};
        acc(0, 8'h84, '0, 4'hF);
        chk("select hold", {5'h0, s}, q);
        give_verdict();
    end
endmodule
bind gpb_pin_select gpb_pin_select_chk gpb_pin_select_chk_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .func_out(func_out),
    .func_oe(func_oe),
    .func_in(func_in),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pad_pullup(pad_pullup)
);
